// ===== hdl/dsadc_seq.sv
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`include "dsadc_consts.svh"

module dsadc_seq #(
    parameter int CYC_LEN = `DSADC_CYC_LEN,
    parameter int AZ_LEN = `DSADC_AZ_LEN,
    parameter int INT_LEN = `DSADC_INT_LEN,
    parameter int OVER_CNT = `DSADC_OVER_CNT,
    parameter int IZ_OVER = `DSADC_IZ_OVER
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run_hold_pin,
    input wire logic integ_crossed,
    input wire logic input_positive,
    input wire logic [`DSADC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`DSADC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output dsadc_pkg::dsadc_flags_t conv_flags,
    output dsadc_pkg::dsadc_phase_t conv_phase,
    output dsadc_pkg::dsadc_digit_t digit_select,
    output dsadc_pkg::dsadc_bcd_t bcd_data,
    output logic strobe_n
);

    // =====================================================
    // Helpers
    function automatic logic [19:0] bcd_inc(input logic [19:0] v);
        logic [19:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 5; i++) begin
            if (carry) begin
                if (r[i*4 +: 4] == 4'h9) begin
                    r[i*4 +: 4] = 4'h0;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
        return r;
    endfunction : bcd_inc

    function automatic logic [3:0] pick_digit(input logic [19:0] v, input logic [4:0] sel);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 5; i++) begin
            r = r | (v[i*4 +: 4] & {4{sel[i]}});
        end
        return r;
    endfunction : pick_digit

    // =====================================================
    // Pin synchronisers
    logic run_s1, run_s2, zc_s1, zc_s2, pol_s1, pol_s2;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            {run_s1, run_s2, zc_s1, zc_s2, pol_s1, pol_s2} <= 6'h00;
        end else begin
            {run_s1, zc_s1, pol_s1} <= {run_hold_pin, integ_crossed, input_positive};
            {run_s2, zc_s2, pol_s2} <= {run_s1, zc_s1, pol_s1};
        end
    end

    // =====================================================
    // Conversion sequencer
    dsadc_pkg::dsadc_phase_t state, next_state;
    logic single, soft_hold, soft_start;
    logic [15:0] cyc;
    logic [14:0] tmr, iz_len;
    logic [19:0] cnt_bcd, reading, next_reading;
    logic busy, over_limit, low_reading, sign_positive, latch_pend, next_over;

    wire run_lvl = run_s2 & ~soft_hold;
    wire az_done = single ? (tmr == 15'(AZ_LEN - 1)) : (cyc == 16'(CYC_LEN - 1));
    wire int_done = cyc == 16'(INT_LEN - 1);
    wire de_over = !zc_s2 && (tmr == 15'(OVER_CNT));
    wire de_done = (state == dsadc_pkg::PH_DEINT) && (zc_s2 || de_over);
    wire int_start = (state == dsadc_pkg::PH_AZ) && az_done && (single || run_lvl);
    wire deint_start = (state == dsadc_pkg::PH_INT) && int_done;
    assign iz_len = over_limit ? 15'(IZ_OVER) : 15'(`DSADC_IZ_NORM);

    always_comb begin
        next_state = state;
        unique case (state)
            dsadc_pkg::PH_IDLE: begin
                if (run_lvl || soft_start) next_state = dsadc_pkg::PH_AZ;
            end
            dsadc_pkg::PH_AZ: begin
                // A cycle started by a pulse runs on; hold is only checked later
                if (az_done) next_state = (single || run_lvl) ? dsadc_pkg::PH_INT : dsadc_pkg::PH_IDLE;
            end
            dsadc_pkg::PH_INT: begin
                if (int_done) next_state = dsadc_pkg::PH_DEINT;
            end
            dsadc_pkg::PH_DEINT: begin
                if (de_done) next_state = dsadc_pkg::PH_IZ;
            end
            dsadc_pkg::PH_IZ: begin
                if (tmr == iz_len - 15'h1) next_state = dsadc_pkg::PH_AZ;
            end
            default: next_state = dsadc_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= dsadc_pkg::PH_IDLE;
            single <= 1'b0;
            tmr <= 15'h0;
            cyc <= 16'h0;
        end else begin
            state <= next_state;
            tmr <= (next_state != state) ? 15'h0 : tmr + 15'h1;
            cyc <= int_start ? 16'h0 : cyc + 16'h1;
            if (state == dsadc_pkg::PH_IDLE && next_state == dsadc_pkg::PH_AZ) begin
                single <= 1'b1;
            end else if (int_start) begin
                single <= 1'b0;
            end
        end
    end

    // =====================================================
    // Count, flags and display latch
    assign next_over = deint_start ? 1'b0 : (de_done ? de_over : over_limit);
    assign next_reading = latch_pend ? cnt_bcd : reading;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_bcd <= 20'h0;
            reading <= 20'h0;
            latch_pend <= 1'b0;
            busy <= 1'b0;
            over_limit <= 1'b0;
            low_reading <= 1'b0;
            sign_positive <= 1'b0;
        end else begin
            busy <= (next_state == dsadc_pkg::PH_INT) || (next_state == dsadc_pkg::PH_DEINT);
            over_limit <= next_over;
            if (deint_start) begin
                cnt_bcd <= 20'h0;
                sign_positive <= pol_s2;
            end else if (state == dsadc_pkg::PH_DEINT && !de_done) begin
                cnt_bcd <= bcd_inc(cnt_bcd);
            end
            if (int_start) begin
                low_reading <= 1'b0;
            end else if (de_done) begin
                low_reading <= !de_over && (tmr <= `DSADC_LOW_CNT);
            end
            latch_pend <= de_done;
            reading <= next_reading;
        end
    end

    // =====================================================
    // Digit scan, strobes and blanking
    logic [4:0] pos, dsel, next_pos, next_dsel;
    logic [7:0] sc, next_sc;
    logic [2:0] strobes_left, next_left;
    logic blank, next_blank;

    // Blanked scan restarts from the top digit so the blink looks clean
    wire restart = de_done || (deint_start && blank);
    wire sc_last = pos[4] ? (sc == 8'(`DSADC_MSD_LEN - 1)) : (sc == 8'(`DSADC_DIG_LEN - 1));
    wire stb_hit = (strobes_left != 3'h0) &&
        (sc == (pos[4] ? 8'(`DSADC_STB_MSD - 1) : 8'(`DSADC_STB_DIG - 1)));
    assign next_pos = restart ? 5'h10 : (sc_last ? {pos[0], pos[4:1]} : pos);
    assign next_sc = (restart || sc_last) ? 8'h0 : sc + 8'h1;
    assign next_left = de_done ? `DSADC_STROBES : (stb_hit ? strobes_left - 3'h1 : strobes_left);
    assign next_blank = deint_start ? 1'b0 :
        ((stb_hit && strobes_left == 3'h1 && over_limit) ? 1'b1 : blank);
    assign next_dsel = next_blank ? 5'h00 : next_pos;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pos <= 5'h10;
            sc <= 8'h0;
            strobes_left <= 3'h0;
            blank <= 1'b0;
            dsel <= 5'h10;
            digit_select <= dsadc_pkg::dsadc_digit_t'(5'h10);
            bcd_data <= dsadc_pkg::dsadc_bcd_t'(4'h0);
            strobe_n <= 1'b1;
        end else begin
            pos <= next_pos;
            sc <= next_sc;
            strobes_left <= next_left;
            blank <= next_blank;
            dsel <= next_dsel;
            digit_select <= dsadc_pkg::dsadc_digit_t'(next_dsel);
            bcd_data <= dsadc_pkg::dsadc_bcd_t'(next_over ? 4'h0 : pick_digit(next_reading, next_dsel));
            strobe_n <= !stb_hit;
        end
    end

    assign conv_phase = state;
    assign conv_flags = '{busy: busy, over_limit: over_limit, low_reading: low_reading,
                          sign_positive: sign_positive};

    // =====================================================
    // AXI4-Lite register slave
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_go = s_axi_arvalid && !s_axi_rvalid;
    wire [`DSADC_ADDR_W-1:0] aw_word = {s_axi_awaddr[`DSADC_ADDR_W-1:2], 2'h0};
    wire [`DSADC_ADDR_W-1:0] ar_word = {s_axi_araddr[`DSADC_ADDR_W-1:2], 2'h0};
    wire aw_ctrl = aw_word == `DSADC_CTRL_OFF;
    wire aw_hit = aw_ctrl || aw_word == `DSADC_STAT_OFF || aw_word == `DSADC_READ_OFF;
    wire ar_hit = ar_word == `DSADC_CTRL_OFF || ar_word == `DSADC_STAT_OFF || ar_word == `DSADC_READ_OFF;
    logic [31:0] stat_word, rd_mux;

    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        stat_word = 32'h0;
        stat_word[`DSADC_ST_BUSY] = busy;
        stat_word[`DSADC_ST_OVER] = over_limit;
        stat_word[`DSADC_ST_LOW] = low_reading;
        stat_word[`DSADC_ST_SIGN] = sign_positive;
        stat_word[`DSADC_ST_BLANK] = blank;
        stat_word[`DSADC_ST_PH_HI:`DSADC_ST_PH_LO] = state;
        rd_mux = 32'h0;
        if (ar_word == `DSADC_CTRL_OFF) rd_mux[`DSADC_CTRL_HOLD] = soft_hold;
        if (ar_word == `DSADC_STAT_OFF) rd_mux = stat_word;
        if (ar_word == `DSADC_READ_OFF) rd_mux = {12'h0, reading};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            soft_hold <= 1'b0;
            soft_start <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DSADC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `DSADC_RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else begin
            soft_start <= wr_go && aw_ctrl && s_axi_wstrb[0] && s_axi_wdata[`DSADC_CTRL_START];
            if (wr_go && aw_ctrl && s_axi_wstrb[0]) soft_hold <= s_axi_wdata[`DSADC_CTRL_HOLD];
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_hit ? `DSADC_RESP_OKAY : `DSADC_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= ar_hit ? `DSADC_RESP_OKAY : `DSADC_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // =====================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic [8:0] msd_len;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            msd_len <= 9'h1;
        end else begin
            msd_len <= next_dsel[4] ? ((dsel[4] && !restart) ? msd_len + 9'h1 : 9'h1) : 9'h0;
        end
    end

    a_busy_az_low: assert property (state == dsadc_pkg::PH_AZ |-> !busy)
        else $error("busy high during auto zero");
    a_busy_rise_int: assert property ($rose(busy) |-> state == dsadc_pkg::PH_INT &&
        $past(state) == dsadc_pkg::PH_AZ)
        else $error("busy rose outside integration start");
    a_busy_fall_cause: assert property ($fell(busy) |-> $past(zc_s2) || $past(tmr) == 15'(OVER_CNT))
        else $error("busy fell without crossing or overrange");
    a_over_on_fall: assert property ($fell(busy) |-> over_limit == ($past(tmr) == 15'(OVER_CNT) &&
        !$past(zc_s2)))
        else $error("over-limit wrong at busy fall");
    a_over_clear_deint: assert property (state == dsadc_pkg::PH_DEINT && $past(state) == dsadc_pkg::PH_INT
        |-> !over_limit)
        else $error("over-limit not cleared at de-integration");
    a_low_on_fall: assert property ($fell(busy) |-> low_reading == (!over_limit &&
        $past(tmr) <= `DSADC_LOW_CNT))
        else $error("low-reading wrong at busy fall");
    a_low_clear_int: assert property (state == dsadc_pkg::PH_INT |-> !low_reading)
        else $error("low-reading set during integration");
    a_reading_latch: assert property ($fell(busy) |=> reading == $past(cnt_bcd))
        else $error("reading not latched after busy fall");
    a_sign_capture: assert property (state == dsadc_pkg::PH_DEINT && $past(state) == dsadc_pkg::PH_INT
        |-> sign_positive == $past(pol_s2))
        else $error("sign not captured");
    a_msd_width: assert property ($fell(dsel[4]) |-> $past(msd_len) == 9'(`DSADC_MSD_LEN))
        else $error("top digit pulse width wrong");
    a_strobe_first: assert property ($fell(busy) |-> ##100 strobe_n ##1 !strobe_n)
        else $error("first strobe not at 101 clocks");
    a_blank_dark: assert property (blank |-> digit_select == '0 && bcd_data == '0)
        else $error("digits driven while blanked");
    a_bcd_over_zero: assert property (over_limit |-> bcd_data == '0)
        else $error("bcd data not zero in overrange");
    a_iz_length: assert property (state == dsadc_pkg::PH_AZ && $past(state) == dsadc_pkg::PH_IZ
        |-> $past(tmr) == $past(iz_len) - 15'h1)
        else $error("integrator zero length wrong");
    a_int_length: assert property (state == dsadc_pkg::PH_DEINT && $past(state) == dsadc_pkg::PH_INT
        |-> $past(cyc) == 16'(INT_LEN - 1))
        else $error("integration length wrong");

    c_overrange: cover property ($fell(busy) && over_limit);
    c_blank: cover property ($rose(blank));
    c_hold_start: cover property (state == dsadc_pkg::PH_IDLE ##1 state == dsadc_pkg::PH_AZ);
    c_strobe: cover property (!strobe_n);

endmodule : dsadc_seq

// ===== hdl/dsadc_consts.svh
`ifndef DSADC_CONSTS_SVH
`define DSADC_CONSTS_SVH

// =====================================================
// Conversion timing in clock periods, and the strobe count
`define DSADC_CYC_LEN 40002
`define DSADC_AZ_LEN 10001
`define DSADC_INT_LEN 10000
`define DSADC_OVER_CNT 20000
`define DSADC_IZ_NORM 200
`define DSADC_IZ_OVER 6200
`define DSADC_LOW_CNT 15'h0708
`define DSADC_MSD_LEN 201
`define DSADC_DIG_LEN 200
`define DSADC_STB_MSD 101
`define DSADC_STB_DIG 100
`define DSADC_STROBES 3'h5

// =====================================================
// Register map, byte offsets
`define DSADC_ADDR_W 8
`define DSADC_CTRL_OFF 8'h00
`define DSADC_STAT_OFF 8'h04
`define DSADC_READ_OFF 8'h08

// Control fields
`define DSADC_CTRL_HOLD 0
`define DSADC_CTRL_START 1

// Status fields
`define DSADC_ST_BUSY 0
`define DSADC_ST_OVER 1
`define DSADC_ST_LOW 2
`define DSADC_ST_SIGN 3
`define DSADC_ST_BLANK 4
`define DSADC_ST_PH_LO 5
`define DSADC_ST_PH_HI 7

`define DSADC_RESP_OKAY 2'h0
`define DSADC_RESP_DECERR 2'h3

`endif

// ===== hdl/dsadc_pkg.sv
package dsadc_pkg;

    typedef enum logic [2:0] {PH_IDLE, PH_AZ, PH_INT, PH_DEINT, PH_IZ} dsadc_phase_t;

    typedef struct packed {
        logic busy;
        logic over_limit;
        logic low_reading;
        logic sign_positive;
    } dsadc_flags_t;

    typedef struct packed {
        logic most_significant_digit_select;
        logic fourth_digit_select;
        logic third_digit_select;
        logic second_digit_select;
        logic least_significant_digit_select;
    } dsadc_digit_t;

    typedef struct packed {
        logic bcd_weight_eight_bit;
        logic bcd_weight_four_bit;
        logic bcd_weight_two_bit;
        logic bcd_weight_one_bit;
    } dsadc_bcd_t;

endpackage : dsadc_pkg

// ===== testbench/dsadc_front_model.sv
module dsadc_front_model (
    input wire logic core_clk,
    input wire dsadc_pkg::dsadc_phase_t conv_phase,
    input wire logic [31:0] cross_delay,
    output logic integ_crossed
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================
    // Comparator of the integrator ramp
    logic [31:0] ramp_cnt;

    initial begin
        ramp_cnt = 32'h0;
        integ_crossed = 1'b0;
    end

    // A huge delay never crosses, which forces an overrange
    always @(posedge core_clk) begin
        if (conv_phase !== dsadc_pkg::PH_DEINT) begin
            ramp_cnt <= 32'h0;
            integ_crossed <= 1'b0;
        end else begin
            ramp_cnt <= ramp_cnt + 32'h1;
            integ_crossed <= (ramp_cnt >= cross_delay);
        end
    end
endmodule : dsadc_front_model

// ===== testbench/dual_slope_adc_output_sequencer_tb_top.sv
`include "dsadc_consts.svh"

module dual_slope_adc_output_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CYC = 400;
    localparam int AZ = 101;
    localparam int INTL = 100;
    localparam int OVR = 200;
    localparam int IZO = 62;

    logic core_clk = 1'b0, rst_n = 1'b0, run_hold_pin = 1'b0, input_positive = 1'b0, integ_crossed;
    logic [31:0] cross_delay = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, strobe_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    dsadc_pkg::dsadc_flags_t conv_flags;
    dsadc_pkg::dsadc_phase_t conv_phase;
    dsadc_pkg::dsadc_digit_t digit_select;
    dsadc_pkg::dsadc_bcd_t bcd_data;
    int num_errors = 0, total_checks = 0, cyc = 0, e0 = 0, t0;
    int ph_cnt [5], ph_busy [5], stb_q [$];

    dsadc_seq #(.CYC_LEN(CYC), .AZ_LEN(AZ), .INT_LEN(INTL), .OVER_CNT(OVR), .IZ_OVER(IZO)) dut (
        .core_clk, .rst_n, .run_hold_pin, .integ_crossed, .input_positive,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .conv_flags, .conv_phase, .digit_select, .bcd_data, .strobe_n
    );

    dsadc_front_model front (.core_clk, .conv_phase, .cross_delay, .integ_crossed);

    // ==========================================
    // Clock and monitors
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    // Phase lengths gathered apart, so the sequence never misses an entry edge
    always @(negedge core_clk) begin
        if (strobe_n === 1'b0) stb_q.push_back(cyc - e0);
        for (int p = 1; p < 5; p++) begin
            if (conv_phase === dsadc_pkg::dsadc_phase_t'(p)) begin
                ph_cnt[p]++;
                ph_busy[p] += (conv_flags.busy === 1'b1);
            end
        end
    end

    // ==========================================
    // Reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task automatic timeout();
        num_errors++;
        $display("Error at %0t: wait ran out", $time);
        results();
    endtask : timeout

    // ==========================================
    // Register bus
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1) && n < 50);
        if (n >= 50) timeout();
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        if (n >= 100) timeout();
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, resp);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] resp);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 50);
        if (n >= 50) timeout();
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        if (n >= 100) timeout();
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        check(s_axi_rresp, resp);
    endtask : axi_rd

    task automatic wait_ph(input dsadc_pkg::dsadc_phase_t ph);
        int n;
        n = 0;
        while (conv_phase !== ph && n < 30000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 30000) timeout();
    endtask : wait_ph

    // ==========================================
    // One single conversion and its display scan
    task automatic conv(input logic pos, input int dly, input logic over, input logic by_pin);
        logic [31:0] rv;
        logic prev_sign, prev_over;
        logic [3:0] samp [5];
        int n;
        prev_sign = conv_flags.sign_positive;
        prev_over = conv_flags.over_limit;
        @(posedge core_clk);
        ph_cnt = '{default: 0};
        ph_busy = '{default: 0};
        input_positive <= pos;
        cross_delay <= dly;
        if (by_pin) begin
            run_hold_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
            run_hold_pin <= 1'b0;
        end else begin
            axi_wr(`DSADC_CTRL_OFF, 32'h2, `DSADC_RESP_OKAY);
        end
        wait_ph(dsadc_pkg::PH_INT);
        check(ph_cnt[1], AZ);
        check(ph_busy[1], 0);
        check(conv_flags.low_reading, 1'b0);
        check(conv_flags.sign_positive, prev_sign);
        wait_ph(dsadc_pkg::PH_DEINT);
        check(ph_cnt[2], INTL);
        check(ph_busy[2], INTL);
        check(conv_flags.sign_positive, pos);
        check(conv_flags.over_limit, 1'b0);
        @(negedge core_clk);
        if (prev_over) check(digit_select, 5'h10);
        wait_ph(dsadc_pkg::PH_IZ);
        e0 = cyc;
        stb_q.delete();
        check(conv_flags.busy, 1'b0);
        check(conv_flags.over_limit, over);
        check(conv_flags.low_reading, !over);
        if (over) check(ph_cnt[3], OVR + 1);
        for (int i = 0; i < 5; i++) begin
            n = 0;
            while (digit_select === (5'h10 >> i) && n < 300) begin
                if (n == 50) samp[i] = bcd_data;
                n++;
                @(negedge core_clk);
            end
            if (!over || i < 4) check(n, (i == 0) ? 201 : 200);
        end
        n = 0;
        while (over && digit_select === 5'h00 && bcd_data === 4'h0 && n < 300) begin
            n++;
            @(negedge core_clk);
        end
        if (over) check(n, 300);
        else check(digit_select, 5'h10);
        check(stb_q.size(), 5);
        foreach (stb_q[k]) check(stb_q[k], 101 + 200 * k);
        check(ph_cnt[4], over ? IZO : 200);
        // Raw count, any fixed comparator offset is left to the reader
        axi_rd(`DSADC_READ_OFF, rv, `DSADC_RESP_OKAY);
        for (int i = 0; i < 5; i++) check(samp[i], over ? 4'h0 : rv[(4 - i) * 4 +: 4]);
    endtask : conv

    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        check(conv_flags, 4'h0);
        check(digit_select, 5'h10);
        check(strobe_n, 1'b1);
        axi_wr(`DSADC_CTRL_OFF, 32'h1, `DSADC_RESP_OKAY);
        axi_rd(`DSADC_CTRL_OFF, rd, `DSADC_RESP_OKAY);
        check(rd, 32'h1);
        axi_wr(`DSADC_STAT_OFF, 32'hff, `DSADC_RESP_OKAY);
        axi_rd(8'h0c, rd, `DSADC_RESP_DECERR);
        axi_wr(8'h0c, 32'h1, `DSADC_RESP_DECERR);
        @(negedge core_clk);
        conv(1'b1, 50, 1'b0, 1'b0);
        axi_rd(`DSADC_CTRL_OFF, rd, `DSADC_RESP_OKAY);
        check(rd, 32'h0);
        axi_rd(`DSADC_STAT_OFF, rd, `DSADC_RESP_OKAY);
        check(rd[3:0], 4'hc);
        @(negedge core_clk);
        conv(1'b0, 100000, 1'b1, 1'b0);
        conv(1'b1, 0, 1'b0, 1'b1);
        @(posedge core_clk);
        run_hold_pin <= 1'b1;
        wait_ph(dsadc_pkg::PH_INT);
        t0 = cyc;
        wait_ph(dsadc_pkg::PH_DEINT);
        wait_ph(dsadc_pkg::PH_INT);
        check(cyc - t0, CYC);
        results();
    end
endmodule : dual_slope_adc_output_sequencer_tb_top
